// ===== design/pcs_pkg.sv
package pcs_pkg;
  // Counter widths of the three memory sizes
  localparam int PC_W_SMALL = 9;
  localparam int PC_W_MID   = 10;
  localparam int PC_W_LARGE = 11;
  localparam int PC_W_MAX   = 11;

  // Reset vectors, top word of each memory size
  localparam logic [PC_W_MAX-1:0] RST_VEC_SMALL = 11'h1FF;
  localparam logic [PC_W_MAX-1:0] RST_VEC_MID   = 11'h3FF;
  localparam logic [PC_W_MAX-1:0] RST_VEC_LARGE = 11'h7FF;

  localparam int INSTR_W = 12;
  localparam int DATA_W  = 8;
  localparam int FILE_AW = 5;
  localparam int BIT_W   = 3;
  localparam int OPC_W   = 4;

  // Instruction field positions
  localparam int OPC_LSB  = 8;
  localparam int BIT_LSB  = 5;
  localparam int FILE_LSB = 0;

  localparam logic [OPC_W-1:0]   OP_BIT_SET        = 4'h5;
  localparam logic [OPC_W-1:0]   OP_BIT_TEST_CLEAR = 4'h6;
  localparam logic [INSTR_W-1:0] INSTR_NOP         = 12'h000;

  // Special file register addresses
  localparam logic [FILE_AW-1:0] ADDR_INDIRECT = 5'h00;
  localparam logic [FILE_AW-1:0] ADDR_STATUS   = 5'h03;
  localparam logic [FILE_AW-1:0] ADDR_FSP      = 5'h04;

  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] FSP_RST    = 8'h00;

  // Page bits in status, bank bits in the file select pointer
  localparam int PAGE_LSB = 5;
  localparam int BANK_LSB = 5;
  localparam int SEL_W    = 2;

  // Register file: common lower half plus banked upper half
  localparam int RF_AW       = 7;
  localparam int COMMON_REGS = 16;
  localparam int BANK_REGS   = 16;
  localparam int NUM_BANKS   = 4;
  localparam int RF_DEPTH    = COMMON_REGS + NUM_BANKS * BANK_REGS;
endpackage

// ===== design/pcs_rf_if.sv
`timescale 1ns/1ps
interface pcs_rf_if;
  import pcs_pkg::*;
  logic [RF_AW-1:0]  rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic [RF_AW-1:0]  wr_addr;
  logic [DATA_W-1:0] wr_data;

  modport core (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
  modport mem  (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

// ===== design/pcs_rf_mem.sv
`timescale 1ns/1ps
module pcs_rf_mem
  import pcs_pkg::*;
#(
  parameter int DEPTH = RF_DEPTH
) (
  input  wire logic i_ref_clk,
  pcs_rf_if.mem     rf
);
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] rd_q;

  // Read data registered; a write in the same cycle returns old data
  always_ff @(posedge i_ref_clk) begin
    if (rf.wr_en && (int'(rf.wr_addr) < DEPTH)) begin
      mem_q[rf.wr_addr] <= rf.wr_data;
    end
    if (int'(rf.rd_addr) < DEPTH) begin
      rd_q <= mem_q[rf.rd_addr];
    end else begin
      rd_q <= 8'h00;
    end
  end

  assign rf.rd_data = rd_q;
endmodule

// ===== design/pcs_sequencer.sv
// Functional notes
// (RQ1) Smallest build: 9-bit counter, 512 words
// (RQ2) Middle build: 10-bit counter, 1K words
// (RQ3) Largest build: 11-bit counter, 2K words
// (RQ4) Addresses above memory wrap into range
// (RQ5) Fetch starts at vector, no-op falls to 000h
// (RQ6) 9-bit counter resets to 1FFh
// (RQ7) 10-bit counter resets to 3FFh
// (RQ8) 11-bit counter resets to 7FFh
// (RQ9) Status bits select program page above 512
// (RQ10) Pointer register selects data bank above 32
// (RQ11) Opcode 0101 sets chosen bit, flags unchanged
// (RQ12) Opcode 0110 skips next when bit clear
// (RQ13) Taken skip squashes prefetch into no-op
// (RQ14) Counter steps by one per fetch, wraps
`timescale 1ns/1ps
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int PC_WIDTH  = PC_W_SMALL,
  parameter int MEM_WORDS = 1 << PC_WIDTH
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_nrst,
  input  wire logic [INSTR_W-1:0]  i_pmem_data,
  output logic      [PC_WIDTH-1:0] o_pmem_addr,
  output logic                     o_pmem_en,
  output logic                     o_exec_valid,
  output logic      [INSTR_W-1:0]  o_exec_instr,
  output logic                     o_skip,
  output logic      [SEL_W-1:0]    o_page_sel,
  output logic      [SEL_W-1:0]    o_data_bank,
  output logic      [DATA_W-1:0]   o_status,
  output logic      [DATA_W-1:0]   o_file_select_pointer
);
  localparam int PCW = PC_WIDTH;
  localparam logic [PCW-1:0] ADDR_MASK = PCW'(MEM_WORDS - 1);

  typedef struct packed {
    logic [PCW-1:0]     pc;
    logic [PCW-1:0]     addr;
    logic               en;
    logic               rom_vld;
    logic [INSTR_W-1:0] ir;
    logic               ir_vld;
    logic [FILE_AW-1:0] ir_eff;
    logic [RF_AW-1:0]   ir_phys;
    logic [DATA_W-1:0]  status;
    logic [DATA_W-1:0]  fsp;
    logic               fwd_vld;
    logic [RF_AW-1:0]   fwd_phys;
    logic [DATA_W-1:0]  fwd_data;
    logic               skip;
    logic [SEL_W-1:0]   page;
    logic [SEL_W-1:0]   bank;
  } pcs_state_type;

  pcs_state_type s_q;
  pcs_state_type s_d;

  pcs_rf_if rf ();

  pcs_rf_mem #(
    .DEPTH (RF_DEPTH)
  ) u_rf_mem (
    .i_ref_clk (i_ref_clk),
    .rf        (rf)
  );

  function automatic logic [PCW-1:0] reset_vector();
    logic [PC_W_MAX-1:0] v;
    v = RST_VEC_SMALL;                                    // RQ6
    if (PCW == PC_W_MID) begin
      v = RST_VEC_MID;                                    // RQ7
    end else if (PCW == PC_W_LARGE) begin
      v = RST_VEC_LARGE;                                  // RQ8
    end
    return v[PCW-1:0];
  endfunction

  // Page bits in use grow with the memory size
  function automatic logic [SEL_W-1:0] page_bits(logic [DATA_W-1:0] st);
    logic [SEL_W-1:0] p;
    p = st[PAGE_LSB +: SEL_W];
    if (PCW <= PC_W_SMALL) begin
      p = 2'h0;
    end else if (PCW == PC_W_MID) begin
      p = {1'b0, p[0]};
    end
    return p;
  endfunction

  // Address zero goes through the file select pointer
  function automatic logic [FILE_AW-1:0] eff_addr(logic [DATA_W-1:0] fsp,
                                                  logic [FILE_AW-1:0] f);
    return (f == ADDR_INDIRECT) ? fsp[FILE_AW-1:0] : f;
  endfunction

  function automatic logic [RF_AW-1:0] phys_addr(logic [DATA_W-1:0] fsp,
                                                 logic [FILE_AW-1:0] a);
    logic [RF_AW-1:0] p;
    if (int'(a) < COMMON_REGS) begin
      p = RF_AW'(a);
    end else begin
      p = RF_AW'(COMMON_REGS) + {1'b0, fsp[BANK_LSB +: SEL_W], a[3:0]};
    end
    return p;
  endfunction

  function automatic logic [PCW-1:0] wrap(logic [PCW-1:0] a);
    return a & ADDR_MASK;
  endfunction

  logic [OPC_W-1:0]  ex_opc;
  logic [BIT_W-1:0]  ex_bit_sel;
  logic [DATA_W-1:0] ex_mask;
  logic [DATA_W-1:0] ex_val;
  logic              ex_set;
  logic              ex_test;
  logic              ex_bit;

  always_comb begin
    s_d = s_q;
    ex_opc = s_q.ir[OPC_LSB +: OPC_W];
    ex_bit_sel = s_q.ir[BIT_LSB +: BIT_W];
    ex_mask = DATA_W'(1) << ex_bit_sel;
    ex_set = s_q.ir_vld && (ex_opc == OP_BIT_SET);
    ex_test = s_q.ir_vld && (ex_opc == OP_BIT_TEST_CLEAR);
    rf.wr_en = 1'b0;
    rf.wr_addr = s_q.ir_phys;
    rf.wr_data = 8'h00;
    // Operand fetch with bypass of last cycle's write
    if (s_q.ir_eff == ADDR_STATUS) begin
      ex_val = s_q.status;
    end else if (s_q.ir_eff == ADDR_FSP) begin
      ex_val = s_q.fsp;
    end else if (s_q.fwd_vld && (s_q.fwd_phys == s_q.ir_phys)) begin
      ex_val = s_q.fwd_data;
    end else begin
      ex_val = rf.rd_data;
    end
    ex_bit = ex_val[ex_bit_sel];

    s_d.fwd_vld = 1'b0;
    if (ex_set) begin
      if (s_q.ir_eff == ADDR_STATUS) begin
        s_d.status = ex_val | ex_mask;                    // RQ11
      end else if (s_q.ir_eff == ADDR_FSP) begin
        s_d.fsp = ex_val | ex_mask;                       // RQ11
      end else begin
        rf.wr_en = 1'b1;                                  // RQ11
        rf.wr_data = ex_val | ex_mask;
        s_d.fwd_vld = 1'b1;
        s_d.fwd_phys = s_q.ir_phys;
        s_d.fwd_data = ex_val | ex_mask;
      end
    end

    // Fetch: step and wrap the counter
    s_d.pc = PCW'(s_q.pc + 1'b1);                         // RQ14 RQ1 RQ2 RQ3
    s_d.addr = wrap(s_d.pc);                              // RQ4 RQ5
    s_d.en = 1'b1;
    s_d.rom_vld = 1'b1;

    s_d.skip = ex_test && !ex_bit;                        // RQ12
    if (s_d.skip) begin
      s_d.ir = INSTR_NOP;                                 // RQ13
      s_d.ir_vld = 1'b1;
    end else begin
      s_d.ir = i_pmem_data;
      s_d.ir_vld = s_q.rom_vld;
    end
    s_d.ir_eff = eff_addr(s_d.fsp, s_d.ir[FILE_LSB +: FILE_AW]);
    s_d.ir_phys = phys_addr(s_d.fsp, s_d.ir_eff);         // RQ10
    rf.rd_addr = s_d.ir_phys;

    s_d.page = page_bits(s_d.status);                     // RQ9
    s_d.bank = s_d.fsp[BANK_LSB +: SEL_W];                // RQ10

    if (!i_nrst) begin
      s_d = '0;
      s_d.pc = reset_vector();                            // RQ6 RQ7 RQ8
      s_d.addr = wrap(reset_vector());                    // RQ5
      s_d.status = STATUS_RST;
      s_d.fsp = FSP_RST;
      s_d.ir = INSTR_NOP;
      rf.wr_en = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  assign o_pmem_addr = s_q.addr;
  assign o_pmem_en = s_q.en;
  assign o_exec_valid = s_q.ir_vld;
  assign o_exec_instr = s_q.ir;
  assign o_skip = s_q.skip;
  assign o_page_sel = s_q.page;
  assign o_data_bank = s_q.bank;
  assign o_status = s_q.status;
  assign o_file_select_pointer = s_q.fsp;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  a_vector_small: assert property (                        // RQ6 RQ1
    (PCW == PC_W_SMALL && $past(!i_nrst)) |-> s_q.pc == PCW'(RST_VEC_SMALL))
    else $error("reset vector wrong for 9-bit counter");
  a_vector_mid: assert property (                          // RQ7 RQ2
    (PCW == PC_W_MID && $past(!i_nrst)) |-> s_q.pc == PCW'(RST_VEC_MID))
    else $error("reset vector wrong for 10-bit counter");
  a_vector_large: assert property (                        // RQ8 RQ3
    (PCW == PC_W_LARGE && $past(!i_nrst)) |-> s_q.pc == PCW'(RST_VEC_LARGE))
    else $error("reset vector wrong for 11-bit counter");
  a_pc_step: assert property (                             // RQ14
    $past(i_nrst) |-> s_q.pc == PCW'($past(s_q.pc) + 1'b1))
    else $error("program counter did not step by one");
  a_addr_wrap: assert property (                           // RQ4
    o_pmem_addr == (s_q.pc & ADDR_MASK))
    else $error("fetch address not wrapped into memory");
  a_top_to_zero: assert property (                         // RQ5
    (o_pmem_addr == ADDR_MASK) |=> (o_pmem_addr == '0))
    else $error("fetch after top word is not address zero");
  a_skip_cause: assert property (                          // RQ12
    ex_test |=> (o_skip == !$past(ex_bit)))
    else $error("skip does not follow tested bit");
  a_skip_squash: assert property (                         // RQ13
    o_skip |-> o_exec_valid && o_exec_instr == INSTR_NOP ##1 !o_skip)
    else $error("skipped slot not a single no-op");
  a_test_no_flags: assert property (                       // RQ12
    ex_test |=> $stable(s_q.status) && $stable(s_q.fsp))
    else $error("bit test changed status or pointer");
  a_set_status: assert property (                          // RQ11
    (ex_set && s_q.ir_eff == ADDR_STATUS)
      |=> s_q.status == ($past(s_q.status) | $past(ex_mask)))
    else $error("bit set on status wrong");
  a_set_memory: assert property (                          // RQ11
    (ex_set && s_q.ir_eff != ADDR_STATUS && s_q.ir_eff != ADDR_FSP)
      |-> rf.wr_en && rf.wr_data[ex_bit_sel] ##1 $stable(s_q.status))
    else $error("bit set on file register wrong");
  a_page_select: assert property (                         // RQ9
    o_page_sel == page_bits(s_q.status))
    else $error("page select not from status bits");
  a_bank_select: assert property (                         // RQ10
    o_data_bank == s_q.fsp[BANK_LSB +: SEL_W])
    else $error("data bank not from pointer bits");
  a_set_bypass: assert property (                          // RQ11 RQ12
    (ex_set && rf.wr_en) ##1 (ex_test && s_q.ir_phys == $past(s_q.ir_phys)
      && ex_bit_sel == $past(ex_bit_sel)) |=> !o_skip)
    else $error("bit just set seen clear by next test");
  a_exec_pipe: assert property (                           // RQ14
    ($past(i_nrst) && !o_skip) |-> o_exec_instr == $past(i_pmem_data))
    else $error("executing word is not the fetched word");

  c_skip_taken: cover property (ex_test && !ex_bit ##1 o_skip);
  c_skip_not_taken: cover property (ex_test && ex_bit);
  c_bit_set: cover property (ex_set ##1 ex_test);
  c_wrap: cover property (o_pmem_addr == ADDR_MASK ##1 o_pmem_addr == '0);
endmodule

// ===== testbench/pcs_pmem_model.sv
`timescale 1ns/1ps
module pcs_pmem_model
  import pcs_pkg::*;
#(
  parameter int AW = PC_W_SMALL
) (
  input  wire logic               i_ref_clk,
  input  wire logic [AW-1:0]      i_addr,
  output logic      [INSTR_W-1:0] o_data
);
  logic [INSTR_W-1:0] mem [1<<AW];

  // Unwritten words read as no-ops
  initial begin
    for (int a = 0; a < (1 << AW); a++) begin
      mem[a] = INSTR_NOP;
    end
  end

  // Synchronous read: word appears one cycle after its address
  always @(posedge i_ref_clk) begin
    o_data <= mem[i_addr];
  end
endmodule

// ===== testbench/tb_pc_sequencer_bit_ops.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb_pc_sequencer_bit_ops;
  import pcs_pkg::*;
  localparam int WID [3] = '{PC_W_SMALL, PC_W_MID, PC_W_LARGE};
  localparam logic [PC_W_MAX-1:0] VEC [3] =
    '{RST_VEC_SMALL, RST_VEC_MID, RST_VEC_LARGE};
  localparam logic [SEL_W-1:0] PGX [3] = '{2'h0, 2'h1, 2'h1};
  // Words 8 to 10 set a banked file bit, then test it bypassed and stored
  localparam logic [INSTR_W-1:0] PROG [12] = '{12'h5A3, 12'h6A3, 12'h123,
    12'h6C3, 12'hABC, 12'h5C4, 12'h6A4, 12'h0FF, 12'h5F5, 12'h6F5,
    12'h6F5, 12'h5A4};
  // Rows: executing word and skip flag per cycle after release
  localparam logic [INSTR_W-1:0] EXP_I [14] = '{12'h000, 12'h5A3, 12'h6A3,
    12'h123, 12'h6C3, 12'h000, 12'h5C4, 12'h6A4, 12'h000, 12'h5F5,
    12'h6F5, 12'h6F5, 12'h5A4, 12'h000};
  localparam logic EXP_S [14] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
    1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  logic                i_ref_clk;
  logic                i_nrst;
  logic [PC_W_MAX-1:0] ad   [3];
  logic [PC_W_MAX-1:0] prev [3];
  logic [INSTR_W-1:0]  ex   [3];
  logic [DATA_W-1:0]   st   [3];
  logic [DATA_W-1:0]   fp   [3];
  logic [SEL_W-1:0]    pg   [3];
  logic [SEL_W-1:0]    bk   [3];
  logic                en   [3];
  logic                vl   [3];
  logic                sk   [3];
  int                  n_fail;
  int                  total_checks;

  for (genvar g = 0; g < 3; g++) begin : gw
    localparam int W = WID[g];
    logic [W-1:0]       addr;
    logic [INSTR_W-1:0] data;
    pcs_pmem_model #(.AW(W)) i_mem (
      .i_ref_clk (i_ref_clk),
      .i_addr    (addr),
      .o_data    (data)
    );
    pcs_sequencer #(.PC_WIDTH(W)) i_dut (
      .i_ref_clk             (i_ref_clk),
      .i_nrst                (i_nrst),
      .i_pmem_data           (data),
      .o_pmem_addr           (addr),
      .o_pmem_en             (en[g]),
      .o_exec_valid          (vl[g]),
      .o_exec_instr          (ex[g]),
      .o_skip                (sk[g]),
      .o_page_sel            (pg[g]),
      .o_data_bank           (bk[g]),
      .o_status              (st[g]),
      .o_file_select_pointer (fp[g])
    );
    assign ad[g] = PC_W_MAX'(addr);
  end

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_reset();
    for (int g = 0; g < 3; g++) begin
      `CHK("rst_addr", VEC[g], ad[g])
      `CHK("rst_en", 1'b0, en[g])
      `CHK("rst_valid", 1'b0, vl[g])
      `CHK("rst_skip", 1'b0, sk[g])
      `CHK("rst_status", STATUS_RST, st[g])
      `CHK("rst_ptr", FSP_RST, fp[g])
    end
  endtask

  task automatic check_release();
    for (int g = 0; g < 3; g++) begin
      `CHK("rel_addr", (VEC[g] + 1) & VEC[g], ad[g])
      `CHK("rel_en", 1'b1, en[g])
    end
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #100000;
    n_fail++;
    test_done();
  end

  initial begin
    i_nrst = 1'b0;
    n_fail = 0;
    total_checks = 0;
    #1;
    for (int a = 0; a < 12; a++) begin
      gw[0].i_mem.mem[a] = PROG[a];
      gw[1].i_mem.mem[a] = PROG[a];
      gw[2].i_mem.mem[a] = PROG[a];
    end
    repeat (3) @(negedge i_ref_clk);
    check_reset();
    i_nrst = 1'b1;
    @(negedge i_ref_clk);
    check_release();
    for (int r = 0; r < 14; r++) begin
      @(negedge i_ref_clk);
      for (int g = 0; g < 3; g++) begin
        `CHK("exec", EXP_I[r], ex[g])
        `CHK("skip", EXP_S[r], sk[g])
        `CHK("valid", 1'b1, vl[g])
        `CHK("addr", PC_W_MAX'(r + 1), ad[g])
      end
    end
    for (int g = 0; g < 3; g++) begin
      `CHK("status", 8'h20, st[g])
      `CHK("ptr", 8'h60, fp[g])
      `CHK("bank", 2'h3, bk[g])
      `CHK("page", PGX[g], pg[g])
      prev[g] = ad[g];
    end
    // Full lap of the largest memory crosses every wrap point
    for (int c = 0; c < 2050; c++) begin
      @(negedge i_ref_clk);
      for (int g = 0; g < 3; g++) begin
        `CHK("step", (prev[g] + 1) & VEC[g], ad[g])
        prev[g] = ad[g];
      end
    end
    i_nrst = 1'b0;
    @(negedge i_ref_clk);
    check_reset();
    i_nrst = 1'b1;
    @(negedge i_ref_clk);
    check_release();
    test_done();
  end
endmodule
